/* shared/ext_irq_regs.vh */
// register map, field positions and timing constants of the external interrupt unit
// Notes on behaviour
// R1: select bit zero puts vectors at flash start, one at boot section base.
// R2: select changes only via change-enable write then select write within four cycles.
// R3: change-enable clears itself four cycles after set, or on the select write.
// R4: interrupts blocked from change-enable write until after following instruction or four cycles.
// R5: automatic blocking leaves the global interrupt-enable flag untouched.
// R6: block interrupts when lock bit forbids vectors in the other section.
// R7: pin interrupts fire even when pins are driven as outputs by the device.
// R8: pin-change requests 2,1,0 follow toggles on enabled pins 23:16, 14:8, 7:0.
// R9: per-group mask registers choose which pins contribute to each request.
// R10: pin changes are seen without the I/O clock so they wake from sleep.
// R11: enabled level-sense pin requests for as long as it stays low.
// R12: edges need the I/O clock; low level is asynchronous and wakes the part.
// R13: level wake needs level held through start-up, else wake without interrupt.
// R14: sense field 00 low, 01 any change, 10 falling, 11 rising.
// R15: interrupt 1 sense field at bits 3:2, interrupt 0 at bits 1:0.
// R16: pin sampled before edge detection; pulses over one clock are caught.
// R17: in low-level mode the source holds low until the instruction ends.
// R18: a dedicated interrupt is active only with global enable and its mask bit.
// R19: mask bit 1 enables external interrupt 1 with its own vector.
// R20: registers answer at data offsets, and at offset minus 0x20 as I/O; code maps I/O only up to 0x3F, so 0x68-0x6D answer at data offsets only.
// R21: mask bit 0 enables external interrupt 0 with its own vector.
// R22: edge flags set on trigger, clear on handler entry or write one, zero in level mode.
// R23: pin-change enable bits 2:0 gate group requests, also with global enable.
// R24: group flags set on enabled pin change, clear on handler entry or write one.
// R25: dedicated pins pass a two-stage synchroniser before edge comparison.
`ifndef EXT_IRQ_REGS_VH
`define EXT_IRQ_REGS_VH
`define IO_SPACE_BIAS    8'h20
`define IO_SPACE_TOP     8'h3F
`define OFF_GRP_FLAG     8'h3B
`define OFF_EXT_FLAG     8'h3C
`define OFF_EXT_MASK     8'h3D
`define OFF_MCU_CTRL     8'h55
`define OFF_GRP_ENABLE   8'h68
`define OFF_SENSE_CTRL   8'h69
`define OFF_PC_MASK0     8'h6B
`define OFF_PC_MASK1     8'h6C
`define OFF_PC_MASK2     8'h6D
`define RESET_BYTE       8'h00
`define BIT_CHANGE_EN    0
`define BIT_PLACE_SEL    1
`define SENSE0_LSB       0
`define SENSE1_LSB       2
`define SENSE_LOW        2'h0
`define SENSE_ANY        2'h1
`define SENSE_FALL       2'h2
`define SENSE_RISE       2'h3
`define CHANGE_WINDOW    3'h4
`define MASK1_WIDTH      7
`endif

/* design/pin_change_group.v */
// one pin-change group: masked toggle detect with async wake output
`default_nettype none
module pin_change_group #(
   parameter W = 8
) (
   input  wire         clk_in,
   input  wire         reset_n_in,
   input  wire [W-1:0] pins_in,
   input  wire [W-1:0] mask_in,
   output wire         change_out,
   output wire         wake_out
);
   reg [W-1:0] s1_q;
   reg [W-1:0] s2_q;
   reg [W-1:0] s3_q;
   always @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         s1_q <= {W{1'b0}};
         s2_q <= {W{1'b0}};
         s3_q <= {W{1'b0}};
      end else begin
         s1_q <= pins_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end
   assign change_out = |((s2_q ^ s3_q) & mask_in); // R8 R9 R24
   // compares raw pin to last clocked level, needs no running clock
   assign wake_out = |((pins_in ^ s3_q) & mask_in); // R10
endmodule
`default_nettype wire

/* design/ext_irq_unit.v */
// external interrupt unit with vector placement control
`default_nettype none
`include "ext_irq_regs.vh"
module ext_irq_unit (
   input  wire        CLK_IN,
   input  wire        RESET_N_IN,
   input  wire [7:0]  ADDR_IN,
   input  wire        IO_SPACE_IN,
   input  wire        WRITE_IN,
   input  wire        READ_IN,
   input  wire [7:0]  WDATA_IN,
   input  wire        GLOBAL_IRQ_EN_IN,
   input  wire        INSTR_DONE_IN,
   input  wire        EXEC_IN_BOOT_IN,
   input  wire        APP_LOCK_PROG_IN,
   input  wire        BOOT_LOCK_PROG_IN,
   input  wire        ACK_EXT0_IN,
   input  wire        ACK_EXT1_IN,
   input  wire [2:0]  ACK_GRP_IN,
   input  wire        EXT_PIN0_IN,
   input  wire        EXT_PIN1_IN,
   input  wire [23:0] PIN_CHANGE_IN,
   output reg  [7:0]  RDATA_OUT,
   output reg         VECTOR_IN_BOOT_OUT,
   output reg         IRQ_EXT0_OUT,
   output reg         IRQ_EXT1_OUT,
   output reg  [2:0]  IRQ_GRP_OUT,
   output reg         WAKE_OUT
);
   reg  [1:0] mask_q;
   reg  [3:0] sense_q;
   reg  [2:0] grp_en_q;
   reg  [7:0] pcm0_q;
   reg  [6:0] pcm1_q;
   reg  [7:0] pcm2_q;
   reg  [1:0] ext_flag_q;
   reg  [2:0] grp_flag_q;
   reg        sel_q;
   reg        chg_en_q;
   reg  [2:0] chg_cnt_q;
   reg        block_q;
   reg        blk_after_q;
   reg  [1:0] e1_q;
   reg  [1:0] e2_q;
   reg  [1:0] e3_q;
   reg  [7:0] dec_addr;
   wire [2:0] grp_change;
   wire [2:0] grp_wake;
   wire [1:0] edge_hit;
   wire [1:0] level_req;
   wire       lock_block;
   wire       irq_ok;

   // load/store use data offsets; in/out add the bias back
   always @* begin
      if (IO_SPACE_IN && ADDR_IN <= `IO_SPACE_TOP)
         dec_addr = ADDR_IN + `IO_SPACE_BIAS; // R20
      else if (IO_SPACE_IN)
         dec_addr = `RESET_BYTE;
      else
         dec_addr = ADDR_IN;
   end

   function wr;
      input [7:0] off;
      begin
         wr = WRITE_IN && (dec_addr == off);
      end
   endfunction

   function sense_hit;
      input [1:0] mode;
      input       now;
      input       was;
      begin
         case (mode) // R14
            `SENSE_ANY:  sense_hit = now ^ was;
            `SENSE_FALL: sense_hit = was & ~now;
            `SENSE_RISE: sense_hit = now & ~was;
            default:     sense_hit = 1'b0;
         endcase
      end
   endfunction

   pin_change_group #(.W(8)) u_grp0 (
      .clk_in     (CLK_IN),
      .reset_n_in (RESET_N_IN),
      .pins_in    (PIN_CHANGE_IN[7:0]),
      .mask_in    (pcm0_q),
      .change_out (grp_change[0]),
      .wake_out   (grp_wake[0])
   );
   pin_change_group #(.W(`MASK1_WIDTH)) u_grp1 (
      .clk_in     (CLK_IN),
      .reset_n_in (RESET_N_IN),
      .pins_in    (PIN_CHANGE_IN[14:8]),
      .mask_in    (pcm1_q),
      .change_out (grp_change[1]),
      .wake_out   (grp_wake[1])
   );
   pin_change_group #(.W(8)) u_grp2 (
      .clk_in     (CLK_IN),
      .reset_n_in (RESET_N_IN),
      .pins_in    (PIN_CHANGE_IN[23:16]),
      .mask_in    (pcm2_q),
      .change_out (grp_change[2]),
      .wake_out   (grp_wake[2])
   );

   // pin inputs are read whatever the port direction, so software can
   // trigger by driving them
   always @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         e1_q <= 2'h0;
         e2_q <= 2'h0;
         e3_q <= 2'h0;
      end else begin
         e1_q <= {EXT_PIN1_IN, EXT_PIN0_IN}; // R7 R25
         e2_q <= e1_q; // R25
         e3_q <= e2_q; // R16
      end
   end

   assign edge_hit[0] = sense_hit(sense_q[`SENSE0_LSB+:2], e2_q[0],
                                  e3_q[0]); // R12 R16
   assign edge_hit[1] = sense_hit(sense_q[`SENSE1_LSB+:2], e2_q[1],
                                  e3_q[1]); // R12 R16
   // level request uses synchronised pin; wake path below is raw
   assign level_req[0] = (sense_q[`SENSE0_LSB+:2] == `SENSE_LOW) &
                         ~e2_q[0]; // R11
   assign level_req[1] = (sense_q[`SENSE1_LSB+:2] == `SENSE_LOW) &
                         ~e2_q[1]; // R11 R13

   assign lock_block = (sel_q & ~EXEC_IN_BOOT_IN & APP_LOCK_PROG_IN) |
                       (~sel_q & EXEC_IN_BOOT_IN & BOOT_LOCK_PROG_IN); // R6
   // global flag only read, never altered by the move block
   assign irq_ok = GLOBAL_IRQ_EN_IN & ~block_q & ~lock_block &
                   ~wr(`OFF_MCU_CTRL); // R4 R5

   // register file
   always @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         mask_q   <= 2'h0;
         sense_q  <= 4'h0;
         grp_en_q <= 3'h0;
         pcm0_q   <= `RESET_BYTE;
         pcm1_q   <= 7'h00;
         pcm2_q   <= `RESET_BYTE;
      end else begin
         if (wr(`OFF_EXT_MASK))
            mask_q <= WDATA_IN[1:0]; // R19 R21
         if (wr(`OFF_SENSE_CTRL))
            sense_q <= WDATA_IN[3:0]; // R15
         if (wr(`OFF_GRP_ENABLE))
            grp_en_q <= WDATA_IN[2:0]; // R23
         if (wr(`OFF_PC_MASK0))
            pcm0_q <= WDATA_IN; // R9
         if (wr(`OFF_PC_MASK1))
            pcm1_q <= WDATA_IN[6:0]; // R9
         if (wr(`OFF_PC_MASK2))
            pcm2_q <= WDATA_IN; // R9
      end
   end

   // flags: set wins over write-one and acknowledge clears
   always @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         ext_flag_q <= 2'h0;
         grp_flag_q <= 3'h0;
      end else begin
         ext_flag_q[0] <= edge_hit[0] | (ext_flag_q[0] & ~ACK_EXT0_IN &
            ~(wr(`OFF_EXT_FLAG) & WDATA_IN[0]) &
            (sense_q[`SENSE0_LSB+:2] != `SENSE_LOW)); // R22
         ext_flag_q[1] <= edge_hit[1] | (ext_flag_q[1] & ~ACK_EXT1_IN &
            ~(wr(`OFF_EXT_FLAG) & WDATA_IN[1]) &
            (sense_q[`SENSE1_LSB+:2] != `SENSE_LOW)); // R22
         grp_flag_q <= grp_change | (grp_flag_q & ~ACK_GRP_IN &
            ~({3{wr(`OFF_GRP_FLAG)}} & WDATA_IN[2:0])); // R24
      end
   end

   // timed vector move
   always @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         sel_q       <= 1'b0;
         chg_en_q    <= 1'b0;
         chg_cnt_q   <= 3'h0;
         block_q     <= 1'b0;
         blk_after_q <= 1'b0;
      end else if (wr(`OFF_MCU_CTRL) && WDATA_IN[`BIT_CHANGE_EN]) begin
         chg_en_q    <= 1'b1; // R2
         chg_cnt_q   <= `CHANGE_WINDOW - 3'h1;
         block_q     <= 1'b1; // R4
         blk_after_q <= 1'b0;
      end else if (wr(`OFF_MCU_CTRL) && chg_en_q) begin
         sel_q       <= WDATA_IN[`BIT_PLACE_SEL]; // R2
         chg_en_q    <= 1'b0; // R3
         chg_cnt_q   <= 3'h0;
         blk_after_q <= 1'b1; // R4
      end else begin
         if (chg_cnt_q != 3'h0)
            chg_cnt_q <= chg_cnt_q - 3'h1;
         if (chg_en_q && chg_cnt_q == 3'h0)
            chg_en_q <= 1'b0; // R3
         // hold until the instruction after the select write retires
         if (blk_after_q) begin
            if (INSTR_DONE_IN) begin
               blk_after_q <= 1'b0;
               block_q     <= 1'b0; // R4
            end
         end else if (block_q && chg_cnt_q == 3'h0)
            block_q <= 1'b0; // R4
      end
   end

   // outputs
   always @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         RDATA_OUT          <= `RESET_BYTE;
         VECTOR_IN_BOOT_OUT <= 1'b0;
         IRQ_EXT0_OUT       <= 1'b0;
         IRQ_EXT1_OUT       <= 1'b0;
         IRQ_GRP_OUT        <= 3'h0;
         WAKE_OUT           <= 1'b0;
      end else begin
         VECTOR_IN_BOOT_OUT <= sel_q; // R1
         IRQ_EXT0_OUT <= irq_ok & mask_q[0] &
                         (ext_flag_q[0] | level_req[0]); // R18 R21
         IRQ_EXT1_OUT <= irq_ok & mask_q[1] &
                         (ext_flag_q[1] | level_req[1]); // R18 R19
         IRQ_GRP_OUT  <= {3{irq_ok}} & grp_en_q & grp_flag_q; // R23
         // registered, so a stopped clock relies on the core's own async path
         WAKE_OUT <= (|(grp_en_q & grp_wake)) |
            (mask_q[0] & ~EXT_PIN0_IN &
             (sense_q[`SENSE0_LSB+:2] == `SENSE_LOW)) |
            (mask_q[1] & ~EXT_PIN1_IN &
             (sense_q[`SENSE1_LSB+:2] == `SENSE_LOW)); // R10 R12
         if (!READ_IN)
            RDATA_OUT <= `RESET_BYTE;
         else if (dec_addr == `OFF_EXT_MASK)
            RDATA_OUT <= {6'h00, mask_q};
         else if (dec_addr == `OFF_EXT_FLAG)
            RDATA_OUT <= {6'h00, ext_flag_q};
         else if (dec_addr == `OFF_GRP_FLAG)
            RDATA_OUT <= {5'h00, grp_flag_q};
         else if (dec_addr == `OFF_MCU_CTRL)
            RDATA_OUT <= {6'h00, sel_q, chg_en_q};
         else if (dec_addr == `OFF_SENSE_CTRL)
            RDATA_OUT <= {4'h0, sense_q};
         else if (dec_addr == `OFF_GRP_ENABLE)
            RDATA_OUT <= {5'h00, grp_en_q};
         else if (dec_addr == `OFF_PC_MASK0)
            RDATA_OUT <= pcm0_q;
         else if (dec_addr == `OFF_PC_MASK1)
            RDATA_OUT <= {1'b0, pcm1_q};
         else if (dec_addr == `OFF_PC_MASK2)
            RDATA_OUT <= pcm2_q;
         else
            RDATA_OUT <= `RESET_BYTE;
      end
   end
endmodule
`default_nettype wire

/* dv/pin_source.sv */
// far-side model of the sources driving the interrupt pins
`default_nettype none
module pin_source (
   input  wire logic        clk_in,
   input  wire logic [25:0] want_in,
   output var  logic        pin0_out,
   output var  logic        pin1_out,
   output var  logic [23:0] grp_out
);
   timeunit 1ns;
   timeprecision 1ps;
   initial {pin1_out, pin0_out, grp_out} = 26'h3FFFFFF;
   // levels stand whole cycles, so no pulse is too short to be caught
   always @(posedge clk_in) begin
      {pin1_out, pin0_out, grp_out} <= want_in;
   end
endmodule
`default_nettype wire

/* dv/ext_irq_checker.sv */
// port-level assertions for the external interrupt unit
`default_nettype none
module ext_irq_checker (
   input wire logic       CLK_IN,
   input wire logic       RESET_N_IN,
   input wire logic [7:0] ADDR_IN,
   input wire logic       IO_SPACE_IN,
   input wire logic       WRITE_IN,
   input wire logic       READ_IN,
   input wire logic [7:0] WDATA_IN,
   input wire logic       GLOBAL_IRQ_EN_IN,
   input wire logic [7:0] RDATA_OUT,
   input wire logic       VECTOR_IN_BOOT_OUT,
   input wire logic       IRQ_EXT0_OUT,
   input wire logic       IRQ_EXT1_OUT,
   input wire logic [2:0] IRQ_GRP_OUT
);
   logic [1:0] msk_q;
   wire logic  hit_m = ADDR_IN == (IO_SPACE_IN ? 8'h1D : 8'h3D);
   wire logic  wr_c = WRITE_IN && ADDR_IN == (IO_SPACE_IN ? 8'h35 : 8'h55);
   wire logic  no_irq = !IRQ_EXT0_OUT && !IRQ_EXT1_OUT && IRQ_GRP_OUT == 3'h0;
   // shadow mask, fed from either address space
   always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN)
         msk_q <= 2'h0;
      else if (WRITE_IN && hit_m)
         msk_q <= WDATA_IN[1:0];
   end
   default clocking @(posedge CLK_IN); endclocking
   default disable iff (!RESET_N_IN);
   idle_read_a: assert property (!$past(READ_IN) |-> RDATA_OUT == 8'h00)
      else $error("read data not zero while idle");
   io_top_a: assert property (READ_IN && IO_SPACE_IN && ADDR_IN > 8'h3F
      |=> RDATA_OUT == 8'h00) else $error("io read above range not zero");
   mask_read_a: assert property (READ_IN && hit_m |=>
      RDATA_OUT == {6'h00, $past(msk_q)}) else $error("mask read mismatch");
   irq_global_a: assert property (!GLOBAL_IRQ_EN_IN [*2] |-> no_irq)
      else $error("request without global enable");
   ext0_mask_a: assert property (!msk_q[0] [*2] |-> !IRQ_EXT0_OUT)
      else $error("pin zero request while masked");
   ext1_mask_a: assert property (!msk_q[1] [*2] |-> !IRQ_EXT1_OUT)
      else $error("pin one request while masked");
   vec_write_a: assert property ($changed(VECTOR_IN_BOOT_OUT) |->
      $past(wr_c, 2)) else $error("vector place moved without write");
   move_block_a: assert property (wr_c && WDATA_IN[0] |=> no_irq [*3])
      else $error("request during vector move");
   cover property (IRQ_EXT0_OUT);
   cover property ($rose(VECTOR_IN_BOOT_OUT));
   cover property (IRQ_GRP_OUT != 3'h0);
endmodule
bind ext_irq_unit ext_irq_checker u_ext_irq_checker (.CLK_IN, .RESET_N_IN,
   .ADDR_IN, .IO_SPACE_IN, .WRITE_IN, .READ_IN, .WDATA_IN, .GLOBAL_IRQ_EN_IN,
   .RDATA_OUT, .VECTOR_IN_BOOT_OUT, .IRQ_EXT0_OUT, .IRQ_EXT1_OUT, .IRQ_GRP_OUT);
`default_nettype wire

/* dv/tb.sv */
// self-checking bench of the external interrupt unit
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0, rst_n = 1'b0, io = 1'b0, we = 1'b0, re = 1'b0;
   logic        gie = 1'b0, done = 1'b0, in_boot = 1'b0, app_lk = 1'b0;
   logic        ack0 = 1'b0, ack1 = 1'b0, boot_lk = 1'b0;
   logic [2:0]  ackg = 3'h0;
   logic [7:0]  addr = 8'h00, wdata = 8'h00;
   logic [25:0] pins = 26'h3FFFFFF;
   wire  logic  p0, p1, vec, irq0, irq1, wake;
   wire  logic [2:0]  irqg;
   wire  logic [7:0]  rdata;
   wire  logic [23:0] pg;
   int          failures = 0, checks_done = 0;
   int          off_pin [3] = '{1, 15, 16};
   int          on_pin [3] = '{0, 8, 17};
   // address, write data, expected read back
   logic [23:0] rows [8] = '{24'h3DFF03, 24'h69FF0F, 24'h68FF07,
      24'h6BA5A5, 24'h6CFF7F, 24'h6D5A5A, 24'h20FF00, 24'h55F000};
   always #2 clk = ~clk;
   pin_source u_pin_source (.clk_in(clk), .want_in(pins), .pin0_out(p0),
      .pin1_out(p1), .grp_out(pg));
   ext_irq_unit u_ext_irq_unit (.CLK_IN(clk), .RESET_N_IN(rst_n),
      .ADDR_IN(addr), .IO_SPACE_IN(io), .WRITE_IN(we), .READ_IN(re),
      .WDATA_IN(wdata), .GLOBAL_IRQ_EN_IN(gie), .INSTR_DONE_IN(done),
      .EXEC_IN_BOOT_IN(in_boot), .APP_LOCK_PROG_IN(app_lk),
      .BOOT_LOCK_PROG_IN(boot_lk), .ACK_EXT0_IN(ack0), .ACK_EXT1_IN(ack1),
      .ACK_GRP_IN(ackg), .EXT_PIN0_IN(p0), .EXT_PIN1_IN(p1),
      .PIN_CHANGE_IN(pg), .RDATA_OUT(rdata), .VECTOR_IN_BOOT_OUT(vec),
      .IRQ_EXT0_OUT(irq0), .IRQ_EXT1_OUT(irq1), .IRQ_GRP_OUT(irqg),
      .WAKE_OUT(wake));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      tick(1);
      addr = a;
      wdata = d;
      we = 1'b1;
      tick(1);
      we = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      tick(1);
      addr = a;
      re = 1'b1;
      tick(1);
      re = 1'b0;
      chk(rdata, exp);
   endtask
   task automatic test_done();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // generous bound: the whole sequence needs well under 2000 cycles
   initial begin
      #20000;
      failures++;
      test_done();
   end
   initial begin
      tick(20);
      rst_n = 1'b1;
      foreach (rows[i]) begin
         rd(rows[i][23:16], 8'h00);
         wr(rows[i][23:16], rows[i][15:8]);
         rd(rows[i][23:16], rows[i][7:0]);
      end
      io = 1'b1;
      wr(8'h1D, 8'h01);
      rd(8'h40, 8'h00);
      io = 1'b0;
      rd(8'h3D, 8'h01);
      gie = 1'b1;
      for (int p = 0; p < 2; p++)
         for (int m = 0; m < 4; m++) begin
            wr(8'h69, 8'(m << (2 * p)));
            wr(8'h3C, 8'h03);
            wr(8'h3D, 8'(1 << p));
            pins[24 + p] = 1'b0;
            tick(6);
            chk(p ? irq1 : irq0, {7'h00, m != 3});
            pins[24 + p] = 1'b1;
            tick(6);
            chk(p ? irq1 : irq0, {7'h00, m != 0});
            gie = 1'b0;
            tick(2);
            chk(p ? irq1 : irq0, 8'h00);
            gie = 1'b1;
            ack0 = (p == 0) && m[0];
            ack1 = (p == 1) && !m[0];
            if (!ack0 && !ack1)
               wr(8'h3C, 8'(1 << p));
            tick(1);
            ack0 = 1'b0;
            ack1 = 1'b0;
            tick(2);
            chk(p ? irq1 : irq0, 8'h00);
         end
      for (int g = 0; g < 3; g++) begin
         pins[off_pin[g]] ^= 1'b1;
         tick(2);
         chk(wake, 8'h00);
         tick(4);
         chk({5'h00, irqg}, 8'h00);
         pins[on_pin[g]] ^= 1'b1;
         tick(2);
         chk(wake, 8'h01);
         tick(4);
         chk({5'h00, irqg}, 8'(1 << g));
         ackg = (g == 1) ? 3'h0 : 3'(1 << g);
         if (g == 1)
            wr(8'h3B, 8'h02);
         tick(1);
         ackg = 3'h0;
         tick(2);
         chk({5'h00, irqg}, 8'h00);
      end
      // a select write after the enable has lapsed must not move vectors
      wr(8'h55, 8'h01);
      tick(6);
      wr(8'h55, 8'h02);
      tick(2);
      chk(vec, 8'h00);
      rd(8'h55, 8'h00);
      wr(8'h69, 8'h00);
      wr(8'h3D, 8'h01);
      pins[24] = 1'b0;
      tick(5);
      chk(irq0, 8'h01);
      chk(wake, 8'h01);
      wr(8'h55, 8'h01);
      chk(irq0, 8'h00);
      wr(8'h55, 8'h02);
      tick(1);
      chk(vec, 8'h01);
      rd(8'h55, 8'h02);
      chk(irq0, 8'h00);
      done = 1'b1;
      tick(1);
      done = 1'b0;
      tick(2);
      chk(irq0, 8'h01);
      app_lk = 1'b1;
      tick(3);
      chk(irq0, 8'h00);
      in_boot = 1'b1;
      tick(3);
      chk(irq0, 8'h01);
      wr(8'h55, 8'h01);
      wr(8'h55, 8'h00);
      done = 1'b1;
      tick(1);
      done = 1'b0;
      boot_lk = 1'b1;
      tick(3);
      chk(irq0, 8'h00);
      in_boot = 1'b0;
      tick(3);
      chk(irq0, 8'h01);
      rst_n = 1'b0;
      tick(20);
      rst_n = 1'b1;
      chk(vec, 8'h00);
      rd(8'h55, 8'h00);
      chk(irq0, 8'h00);
      chk(wake, 8'h00);
      test_done();
   end
endmodule
`default_nettype wire
